// *** logic/adctr_ctrl.v ***
// Converter trigger, sequencing and re-conversion control
`timescale 1ns/1ps
`include "adctr_regs.vh"

module adctr_ctrl (
    // Clock and reset
    input wire clock,
    input wire rstn,
    // Register port
    input wire [5:0] addr,
    input wire [7:0] wrData,
    input wire wrStrobe,
    input wire rdStrobe,
    output reg [15:0] rdData,
    // External trigger pin
    input wire extConvTriggerPin,
    // Timer unit 1 interrupt signals
    input wire [3:0] timer1MatchIrq,
    input wire [3:0] timer1ExtIrq,
    // Timer 5 channel 3 and CPU interrupt paths
    output wire timer5CaptureStrobe,
    output wire timer5MatchIrq,
    output wire timer5ExtIrq,
    // Analog front end
    input wire [9:0] sampleData,
    output reg [1:0] sampleChannel,
    output reg sampleActive,
    // Conversion end
    output reg convDoneIrq
);

    localparam ST_IDLE = 2'b00;
    localparam ST_DELAY = 2'b01;
    localparam ST_CONV = 2'b10;

    // Start delays rounded up to whole clocks
    localparam integer PRE_SW_I = `ADCTR_X10_TO_CYC(`ADCTR_PRE_SW_X10);
    localparam integer PRE_TEXT_I = `ADCTR_X10_TO_CYC(`ADCTR_PRE_TEXT_X10);
    localparam integer PRE_TCMP_I = `ADCTR_X10_TO_CYC(`ADCTR_PRE_TCMP_X10);
    localparam integer PRE_EXT_I = `ADCTR_X10_TO_CYC(`ADCTR_PRE_EXT_X10);
    localparam [8:0] PRE_SW = PRE_SW_I[8:0];
    localparam [8:0] PRE_TEXT = PRE_TEXT_I[8:0];
    localparam [8:0] PRE_TCMP = PRE_TCMP_I[8:0];
    localparam [8:0] PRE_EXT = PRE_EXT_I[8:0];
    localparam [8:0] ONE = 9'h001;

    reg [7:0] convChannelCtrlReg;
    reg [7:0] convTimingTriggerReg;
    reg [7:0] timer5ModeReg;
    reg [1:0] state;
    reg [1:0] next_state;
    reg [8:0] count;
    reg [8:0] next_count;
    reg [1:0] seqIdx;
    reg [1:0] next_seqIdx;
    reg repeatPending;
    reg next_repeatPending;
    reg pinLast;
    reg storeNow;
    reg doneNow;
    reg [9:0] convResultReg [0:3];

    wire ceBit = convChannelCtrlReg[`ADCTR_F_CE];
    wire scanMode = convChannelCtrlReg[`ADCTR_F_SCAN];
    wire buf4Mode = convChannelCtrlReg[`ADCTR_F_BUF4];
    wire [1:0] selChannel = convChannelCtrlReg[`ADCTR_F_CHHI:`ADCTR_F_CHLO];
    wire [2:0] convTimeSelect = convTimingTriggerReg[`ADCTR_F_FRHI:`ADCTR_F_FRLO];
    wire [2:0] triggerSourceSelect = convTimingTriggerReg[`ADCTR_F_TRHI:`ADCTR_F_TRLO];
    wire multiMode = scanMode | buf4Mode;
    wire lastConv = ~multiMode | (seqIdx == `ADCTR_LAST_IDX);
    wire swWrite = wrStrobe & (addr == `ADCTR_A_CHAN);
    wire ceRise = swWrite & wrData[`ADCTR_F_CE] & ~ceBit;
    wire ceClear = swWrite & ~wrData[`ADCTR_F_CE];

    // Falling edge of the shared pin
    wire pinFall = pinLast & ~extConvTriggerPin; // R24

    // Shared pin also feeds timer 5 and the CPU interrupt path
    assign timer5CaptureStrobe = pinFall & ~timer5ModeReg[`ADCTR_F_CMPSEL]; // R1
    assign timer5MatchIrq = pinFall & ~timer5ModeReg[`ADCTR_F_MASK] & ~timer5ModeReg[`ADCTR_F_ISEL]; // R3
    assign timer5ExtIrq = pinFall & ~timer5ModeReg[`ADCTR_F_MASK] & timer5ModeReg[`ADCTR_F_ISEL]; // R4

    // Start source per mode
    reg hwTrigger;
    reg [8:0] preCycles;
    always @* begin
        hwTrigger = 1'b0;
        preCycles = PRE_SW; // R17
        case (triggerSourceSelect)
            `ADCTR_TRG_TCMP: begin
                hwTrigger = timer1MatchIrq[0]; // R5
                preCycles = PRE_TCMP; // R19
            end
            `ADCTR_TRG_TEXT: begin
                hwTrigger = timer1ExtIrq[0];
                preCycles = PRE_TEXT; // R18
            end
            `ADCTR_TRG_EXT: begin
                hwTrigger = pinFall; // R6
                preCycles = PRE_EXT; // R20
            end
            default: begin
                hwTrigger = 1'b0;
                preCycles = PRE_SW;
            end
        endcase
    end

    wire swMode = (triggerSourceSelect == `ADCTR_TRG_SW);
    wire startReq = swMode ? ceRise : (ceBit & hwTrigger);
    // Timer 1 channel 1-3 sources seen while converting, hardware trigger modes only
    wire repeatCause = ~swMode & ((|timer1MatchIrq[3:1]) | (|timer1ExtIrq[3:1])); // R7 R9

    // Conversion length
    reg [8:0] convCycles;
    always @* begin
        case (convTimeSelect)
            `ADCTR_FR_96: convCycles = `ADCTR_CONV_96; // R21 R22
            `ADCTR_FR_A: convCycles = `ADCTR_CONV_A;
            `ADCTR_FR_B: convCycles = `ADCTR_CONV_B;
            `ADCTR_FR_C: convCycles = `ADCTR_CONV_C;
            default: convCycles = `ADCTR_CONV_96;
        endcase
    end

    // Sequencer
    always @* begin
        next_state = state;
        next_count = count;
        next_seqIdx = seqIdx;
        next_repeatPending = repeatPending;
        storeNow = 1'b0;
        doneNow = 1'b0;
        case (state)
            ST_IDLE: begin
                if (startReq & ~ceClear) begin
                    next_state = ST_DELAY;
                    next_count = preCycles - ONE;
                    next_repeatPending = 1'b0;
                end
            end
            ST_DELAY: begin
                if (count == 9'h000) begin
                    next_state = ST_CONV;
                    next_count = convCycles - ONE;
                end else begin
                    next_count = count - ONE;
                end
            end
            ST_CONV: begin
                if (repeatCause)
                    next_repeatPending = 1'b1;
                if (count == 9'h000) begin
                    storeNow = 1'b1;
                    next_count = convCycles - ONE;
                    if (repeatPending | repeatCause) begin
                        // Redo same entry, no new trigger needed
                        next_repeatPending = 1'b0; // R8
                        next_state = ST_CONV; // R10 R13
                        doneNow = lastConv; // R10 R15
                    end else begin
                        doneNow = lastConv; // R11 R14
                        next_seqIdx = lastConv ? 2'h0 : seqIdx + 2'h1;
                        if (swMode & ~lastConv)
                            next_state = ST_CONV;
                        else
                            next_state = ST_IDLE;
                    end
                end else begin
                    next_count = count - ONE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        if (ceClear) begin
            // Abort without storing
            next_state = ST_IDLE; // R25
            next_seqIdx = 2'h0;
            next_repeatPending = 1'b0;
            storeNow = 1'b0;
            doneNow = 1'b0;
        end
    end

    always @(posedge clock) begin
        if (!rstn) begin
            state <= ST_IDLE;
            count <= 9'h000;
            seqIdx <= 2'h0;
            repeatPending <= 1'b0;
            pinLast <= 1'b1;
            convDoneIrq <= 1'b0;
            sampleActive <= 1'b0;
            sampleChannel <= 2'h0;
        end else begin
            state <= next_state;
            count <= next_count;
            seqIdx <= next_seqIdx;
            repeatPending <= next_repeatPending;
            pinLast <= extConvTriggerPin;
            convDoneIrq <= doneNow; // R26
            sampleActive <= (next_state == ST_CONV);
            sampleChannel <= (scanMode ? next_seqIdx : selChannel);
        end
    end

    // Result storage entry for this conversion
    wire [1:0] storeIdx = multiMode ? seqIdx : selChannel;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : gRes
            always @(posedge clock) begin
                if (!rstn)
                    convResultReg[gi] <= 10'h000;
                else if (storeNow && storeIdx == gi)
                    convResultReg[gi] <= sampleData; // R11 R13
            end
        end
    endgenerate

    // Register writes
    always @(posedge clock) begin
        if (!rstn) begin
            convChannelCtrlReg <= `ADCTR_RST_CHAN;
            convTimingTriggerReg <= `ADCTR_RST_TRIG;
            timer5ModeReg <= `ADCTR_RST_TIM5;
        end else if (wrStrobe) begin
            case (addr)
                `ADCTR_A_CHAN: convChannelCtrlReg <= wrData;
                `ADCTR_A_TRIG: convTimingTriggerReg <= wrData;
                `ADCTR_A_TIM5: timer5ModeReg <= wrData;
                default: convChannelCtrlReg <= convChannelCtrlReg;
            endcase
        end
    end

    // Register reads, data in the following cycle
    always @(posedge clock) begin
        if (!rstn) begin
            rdData <= 16'h0000;
        end else if (rdStrobe) begin
            case (addr)
                `ADCTR_A_CHAN: rdData <= {8'h00, convChannelCtrlReg};
                `ADCTR_A_TRIG: rdData <= {8'h00, convTimingTriggerReg};
                `ADCTR_A_TIM5: rdData <= {8'h00, timer5ModeReg};
                `ADCTR_A_STAT: rdData <= {10'h000, seqIdx, repeatPending, 1'b0, state};
                `ADCTR_A_RES0: rdData <= {6'h00, convResultReg[0]}; // R12
                `ADCTR_A_RES1: rdData <= {6'h00, convResultReg[1]};
                `ADCTR_A_RES2: rdData <= {6'h00, convResultReg[2]};
                `ADCTR_A_RES3: rdData <= {6'h00, convResultReg[3]};
                default: rdData <= 16'h0000;
            endcase
        end else begin
            rdData <= 16'h0000;
        end
    end

endmodule // adctr_ctrl

// *** logic/adctr_regs.vh ***
// Constants for the converter trigger and re-conversion control block
// Operation
// R1: External trigger pin feeds converter start and timer 5 capture input together.
// R2: Software avoiding capture interrupts sets timer 5 channel 3 compare and masks it.
// R3: Select bit 0 and unmasked: pin event reaches CPU as compare match interrupt.
// R4: Select bit 1 and unmasked: pin event reaches CPU as external interrupt.
// R5: Timer 1 trigger mode starts on timer 1 channel 0 match interrupt.
// R6: External trigger mode starts on the external trigger pin.
// R7: Timer 1 match 1-3 or external 1-3 during conversion may cause one repeat.
// R8: No other interrupt source during conversion means no repeat.
// R9: Timer 1 capture external interrupt lines count as repeat causes.
// R10: Single-buffer repeat: first conversion stores and interrupts before repeat starts.
// R11: Single-buffer repeat overwrites same result and interrupts again.
// R12: Result registers stay readable during repeat, showing stored value.
// R13: Four-buffer and scan: finish, store, redo same channel, overwrite result.
// R14: After repeat the sequence continues; interrupt when sequence completes.
// R15: Repeat on final conversion: interrupt, redo final conversion, interrupt again.
// R16: Software needing no repeats uses software trigger from interrupt handlers.
// R17: Software trigger completes 4 clocks plus conversion clocks after trigger.
// R18: Timer trigger by external interrupt completes 5.5-6.5 plus conversion clocks.
// R19: Timer trigger by compare match completes 2.5 plus conversion clocks.
// R20: External trigger completes 4.5-5.5 plus conversion clocks after pin event.
// R21: Conversion time select 010 gives 96 clocks per conversion.
// R22: Mode register 02H software, 22H/32H timer, 62H external, all 96 clocks.
// R23: Software selects external trigger with source 110 and pin control mode.
// R24: Only the falling edge of the external trigger pin is a trigger.
// R25: Clearing enable mid-conversion aborts at once, results unchanged.
// R26: Conversion-end interrupt is a one-clock pulse for every completion.
`ifndef ADCTR_REGS_VH
`define ADCTR_REGS_VH

// Register offsets
`define ADCTR_A_CHAN 6'h00
`define ADCTR_A_TRIG 6'h04
`define ADCTR_A_TIM5 6'h08
`define ADCTR_A_STAT 6'h0C
`define ADCTR_A_RES0 6'h10
`define ADCTR_A_RES1 6'h14
`define ADCTR_A_RES2 6'h18
`define ADCTR_A_RES3 6'h1C

// Channel control fields
`define ADCTR_F_CE 0
`define ADCTR_F_SCAN 1
`define ADCTR_F_BUF4 2
`define ADCTR_F_CHLO 4
`define ADCTR_F_CHHI 5
// Timing and trigger fields
`define ADCTR_F_FRLO 0
`define ADCTR_F_FRHI 2
`define ADCTR_F_TRLO 4
`define ADCTR_F_TRHI 6
// Timer 5 channel 3 fields
`define ADCTR_F_ISEL 0
`define ADCTR_F_CMPSEL 1
`define ADCTR_F_MASK 2

// Reset values
`define ADCTR_RST_CHAN 8'h00
`define ADCTR_RST_TRIG 8'h02
`define ADCTR_RST_TIM5 8'h06

// Trigger source codes
`define ADCTR_TRG_SW 3'h0
`define ADCTR_TRG_TCMP 3'h2
`define ADCTR_TRG_TEXT 3'h3
`define ADCTR_TRG_EXT 3'h6

// Conversion time select codes and lengths in clocks
`define ADCTR_FR_96 3'h2
`define ADCTR_FR_A 3'h0
`define ADCTR_FR_B 3'h1
`define ADCTR_FR_C 3'h3
`define ADCTR_CONV_96 9'h060
`define ADCTR_CONV_A 9'h0A8
`define ADCTR_CONV_B 9'h078
`define ADCTR_CONV_C 9'h048

// Trigger to conversion start times, in tenths of a clock
`define ADCTR_PRE_SW_X10 40
`define ADCTR_PRE_TEXT_X10 55
`define ADCTR_PRE_TCMP_X10 25
`define ADCTR_PRE_EXT_X10 45
`define ADCTR_X10_TO_CYC(t) (((t) + 9) / 10)

// Sequence
`define ADCTR_LAST_IDX 2'h3
`define ADCTR_RES_W 10

`endif

// *** testbench/adctr_properties.sv ***
// Checker for trigger routing, latency and completion pulses
`timescale 1ns/1ps
module adctr_properties (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Register writes
    input wire logic [5:0] addr,
    input wire logic [7:0] wrData,
    input wire logic wrStrobe,
    // Triggers
    input wire logic extConvTriggerPin,
    input wire logic [3:0] timer1MatchIrq,
    input wire logic [3:0] timer1ExtIrq,
    // Outputs watched
    input wire logic timer5CaptureStrobe,
    input wire logic timer5MatchIrq,
    input wire logic timer5ExtIrq,
    input wire logic sampleActive,
    input wire logic convDoneIrq
);
    logic [7:0] chan, trig, tim5;
    logic pinQ;
    wire fell = pinQ & ~extConvTriggerPin;
    wire idle = chan[0] & ~sampleActive & (chan[2:1] == 2'h0);
    // Shadow copies of the control registers
    always @(posedge clock) begin
        if (!rstn) begin
            chan <= 8'h00;
            trig <= 8'h02;
            tim5 <= 8'h06;
            pinQ <= 1'b1;
        end else begin
            pinQ <= extConvTriggerPin;
            if (wrStrobe && addr == 6'h00) chan <= wrData;
            if (wrStrobe && addr == 6'h04) trig <= wrData;
            if (wrStrobe && addr == 6'h08) tim5 <= wrData;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    capture_route_a: assert property (timer5CaptureStrobe == (fell & ~tim5[1]))
        else $error("capture strobe wrong");
    match_route_a: assert property (timer5MatchIrq == (fell & ~tim5[2] & ~tim5[0]))
        else $error("timer5 match irq wrong");
    extirq_route_a: assert property (timer5ExtIrq == (fell & ~tim5[2] & tim5[0]))
        else $error("timer5 ext irq wrong");
    done_pulse_a: assert property (convDoneIrq |=> !convDoneIrq)
        else $error("done pulse too long");
    abort_stop_a: assert property (wrStrobe && addr == 6'h00 && !wrData[0] |=> !sampleActive && !convDoneIrq)
        else $error("abort did not stop");
    sw_latency_a: assert property (wrStrobe && addr == 6'h00 && wrData[0] && wrData[2:1] == 2'h0 && !chan[0]
        && trig == 8'h02 |-> ##101 convDoneIrq) else $error("software latency wrong");
    pin_latency_a: assert property (fell && trig == 8'h62 && idle |-> ##102 convDoneIrq)
        else $error("pin latency wrong");
    tmatch_latency_a: assert property (timer1MatchIrq[0] && trig == 8'h22 && idle |-> ##100 convDoneIrq)
        else $error("timer match latency wrong");
    text_latency_a: assert property (timer1ExtIrq[0] && trig == 8'h32 && idle |-> ##103 convDoneIrq)
        else $error("timer ext latency wrong");
    cover property (fell && trig == 8'h62);
    cover property (convDoneIrq ##96 convDoneIrq);
    cover property (wrStrobe && addr == 6'h00 && !wrData[0] && sampleActive);
endmodule // adctr_properties

bind adctr_ctrl adctr_properties adctr_properties_i (.clock, .rstn, .addr, .wrData, .wrStrobe, .extConvTriggerPin,
    .timer1MatchIrq, .timer1ExtIrq, .timer5CaptureStrobe, .timer5MatchIrq, .timer5ExtIrq, .sampleActive, .convDoneIrq);

// *** testbench/adctr_partner.sv ***
// Timer unit, trigger pin and analog source model
`timescale 1ns/1ps
module adctr_partner (
    // Clock and commands
    input wire logic clock,
    input wire logic firePin,
    input wire logic [3:0] fireMatch,
    input wire logic [3:0] fireExt,
    input wire logic [7:0] pat,
    // Converter side
    input wire logic [1:0] sampleChannel,
    input wire logic sampleActive,
    output logic extConvTriggerPin,
    output logic [3:0] timer1MatchIrq,
    output logic [3:0] timer1ExtIrq,
    output logic [9:0] sampleData
);
    logic [1:0] lowCnt = 2'h0;
    logic [9:0] noise = 10'h2A5;
    initial extConvTriggerPin = 1'b1;
    always @(posedge clock) begin
        timer1MatchIrq <= fireMatch;
        timer1ExtIrq <= fireExt;
        noise <= ~noise;
        if (firePin) begin
            extConvTriggerPin <= 1'b0;
            lowCnt <= 2'h3;
        end else if (lowCnt != 2'h0) begin
            lowCnt <= lowCnt - 2'h1;
        end else begin
            extConvTriggerPin <= 1'b1;
        end
    end
    // Source gives toggling noise outside conversions
    assign sampleData = sampleActive ? {sampleChannel, pat} : noise;
endmodule // adctr_partner

// *** testbench/adctr_ctrl_tb.sv ***
// Self-checking bench for the converter trigger control
`timescale 1ns/1ps
module adctr_ctrl_tb;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic [5:0] addr = 6'h00;
    logic [7:0] wrData = 8'h00, pat = 8'h00, keep;
    logic wrStrobe = 1'b0, rdStrobe = 1'b0, firePin = 1'b0, rdPend = 1'b0;
    logic [3:0] fireMatch = 4'h0, fireExt = 4'h0, timer1MatchIrq, timer1ExtIrq;
    logic [15:0] rdData;
    logic [9:0] sampleData;
    logic [1:0] sampleChannel;
    logic extConvTriggerPin, timer5CaptureStrobe, timer5MatchIrq, timer5ExtIrq, sampleActive, convDoneIrq;
    logic [15:0] rdQ[$];
    logic [2:0] routeQ[$];
    logic pinQ = 1'b1;
    logic [7:0] tim5Shadow = 8'h06;
    int doneQ[$];
    int cyc = 0, error_cnt = 0, total_checks = 0, seed = 32'h399B9AC7;
    always #5 clock = ~clock;
    adctr_ctrl adctr_ctrl_i (.clock, .rstn, .addr, .wrData, .wrStrobe, .rdStrobe, .rdData, .extConvTriggerPin,
        .timer1MatchIrq, .timer1ExtIrq, .timer5CaptureStrobe, .timer5MatchIrq, .timer5ExtIrq, .sampleData,
        .sampleChannel, .sampleActive, .convDoneIrq);
    adctr_partner adctr_partner_i (.clock, .firePin, .fireMatch, .fireExt, .pat, .sampleChannel, .sampleActive,
        .extConvTriggerPin, .timer1MatchIrq, .timer1ExtIrq, .sampleData);
    task automatic tick(int n = 1);
        repeat (n) @(posedge clock);
    endtask
    task automatic wr(logic [5:0] a, logic [7:0] d);
        if (a == 6'h08) tim5Shadow = d;
        addr <= a;
        wrData <= d;
        wrStrobe <= 1'b1;
        tick();
        wrStrobe <= 1'b0;
        tick();
    endtask
    task automatic rd(logic [5:0] a, logic [15:0] e);
        rdQ.push_back(e);
        addr <= a;
        rdStrobe <= 1'b1;
        tick();
        rdStrobe <= 1'b0;
        tick();
    endtask
    // Kind 0 pin, 1 timer match, 2 timer external; lat is start delay plus conversion
    task automatic pulse(int k, int idx, int lat);
        if (lat > 0) doneQ.push_back(cyc + 3 + lat);
        if (k == 0) routeQ.push_back({~tim5Shadow[1], ~tim5Shadow[2] & ~tim5Shadow[0], ~tim5Shadow[2] & tim5Shadow[0]});
        if (k == 0) firePin <= 1'b1;
        if (k == 1) fireMatch[idx] <= 1'b1;
        if (k == 2) fireExt[idx] <= 1'b1;
        tick();
        firePin <= 1'b0;
        fireMatch <= 4'h0;
        fireExt <= 4'h0;
        tick();
    endtask
    task automatic drain(int n);
        for (int t = 0; t < 400 && doneQ.size() > n; t++) tick();
    endtask
    task automatic chk_rd(logic [15:0] e, logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD rdData exp %h got %h", e, g);
        end
    endtask
    task automatic chk_route(logic [2:0] e, logic [2:0] g);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD timer5 route exp %b got %b", e, g);
        end
    endtask
    task automatic chk_done(int e, int g);
        total_checks++;
        if (g != e) begin
            error_cnt++;
            $display("BAD convDoneIrq exp %0d got %0d", e, g);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Result watcher
    always @(posedge clock) begin
        cyc <= cyc + 1;
        rdPend <= rdStrobe;
        pinQ <= extConvTriggerPin;
        if (rdPend === 1'b1) chk_rd(rdQ.size() ? rdQ.pop_front() : 16'hDEAD, rdData);
        if (rstn && convDoneIrq !== 1'b0) chk_done(doneQ.size() ? doneQ.pop_front() : -1, cyc);
        if (pinQ === 1'b1 && extConvTriggerPin === 1'b0)
            chk_route(routeQ.size() ? routeQ.pop_front() : 3'h7, {timer5CaptureStrobe, timer5MatchIrq, timer5ExtIrq});
    end
    initial begin
        tick(20000);
        error_cnt++;
        report_and_stop();
    end
    initial begin
        tick(10);
        rstn <= 1'b1;
        tick(2);
        rd(6'h00, 16'h0000);
        rd(6'h04, 16'h0002);
        rd(6'h08, 16'h0006);
        rd(6'h3C, 16'h0000);
        for (int v = 0; v < 8; v++) begin
            wr(6'h08, 8'(v));
            pulse(0, 0, 0);
            tick(4);
        end
        wr(6'h08, 8'h06);
        $display("test routing finished");
        pat <= 8'($random(seed));
        wr(6'h04, 8'h02);
        doneQ.push_back(cyc + 102);
        wr(6'h00, 8'h01);
        drain(0);
        rd(6'h10, {8'h00, pat});
        wr(6'h00, 8'h00);
        wr(6'h04, 8'h62);
        wr(6'h00, 8'h21);
        pulse(0, 0, 101);
        drain(0);
        rd(6'h18, {6'h00, 2'h2, pat});
        $display("test software and pin finished");
        wr(6'h04, 8'h22);
        wr(6'h00, 8'h11);
        pulse(1, 0, 99);
        doneQ.push_back(doneQ[0] + 96);
        tick(40);
        pulse(2, 2, 0);
        rd(6'h0C, 16'h000A);
        drain(1);
        rd(6'h14, {6'h00, 2'h1, pat});
        pat <= 8'($random(seed));
        drain(0);
        rd(6'h14, {6'h00, 2'h1, pat});
        wr(6'h04, 8'h32);
        wr(6'h00, 8'h31);
        pulse(2, 0, 102);
        drain(0);
        rd(6'h1C, {6'h00, 2'h3, pat});
        $display("test single repeat finished");
        for (int m = 0; m < 2; m++) begin
            wr(6'h00, m ? 8'h03 : 8'h05);
            pat <= 8'($random(seed));
            for (int i = 0; i < 4; i++) begin
                pulse(2, 0, i == 3 ? 102 : 0);
                if (i == 3) doneQ.push_back(doneQ[0] + 96);
                tick(40);
                if (i == 1) pulse(1, 3, 0);
                if (i == 3) pulse(1, 2, 0);
                tick(100);
                if (i == 0) keep = pat;
                // New data between first store and redo store
                if (i == 1) pat <= 8'($random(seed));
                tick(150);
            end
            drain(0);
            for (int i = 0; i < 4; i++) rd(6'h10 + 6'(4 * i), {6'h00, m ? 2'(i) : 2'h0, i ? pat : keep});
        end
        $display("test sequence repeat finished");
        for (int f = 0; f < 3; f++) begin
            wr(6'h00, 8'h00);
            wr(6'h04, 8'(f == 2 ? 3 : f));
            doneQ.push_back(cyc + 6 + (f == 0 ? 168 : f == 1 ? 120 : 72));
            wr(6'h00, 8'h01);
            drain(0);
        end
        $display("test time select finished");
        keep = pat;
        pat <= 8'($random(seed));
        wr(6'h04, 8'h62);
        wr(6'h00, 8'h05);
        pulse(0, 0, 0);
        tick(40);
        wr(6'h00, 8'h00);
        tick(150);
        rd(6'h10, {8'h00, keep});
        chk_done(0, doneQ.size());
        $display("test abort finished");
        report_and_stop();
    end
endmodule // adctr_ctrl_tb
